// ---- hw/scp_command_port.sv ----
// Bus slave, command registers and supply/battery state logic of the charger
`timescale 1ns/1ps
`default_nettype none
module scp_command_port (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_ce,
  input wire logic i_scl,
  input wire logic i_sda,
  input wire logic i_adapter_detected,
  input wire logic i_power_fail_cmp,
  input wire logic i_battery_inserted_cmp,
  input wire logic i_battery_sense_pin_below_low,
  input wire logic i_battery_sense_pin_above_resume,
  input wire logic i_logic_supply_low,
  input wire logic i_overtemp_latched_flag,
  input wire logic i_thermistor_underrange,
  output logic o_sda_o,
  output logic o_sda_oe,
  output logic o_source_switch_driver,
  output logic o_charge_enable,
  output logic o_float_charge,
  output logic o_current_limited,
  output logic [15:0] o_current_setpoint,
  output logic [15:0] o_voltage_setpoint,
  output logic [15:0] o_control_word
);

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    scp_pkg::scp_state_t st;
    logic [3:0] bitcnt;
    logic [7:0] shreg;
    logic [7:0] byte_buf;
    logic [1:0] bytenum;
    logic rw;
    logic acked;
    logic [7:0] cmd;
    logic sda_oe;
    logic scl_d;
    logic sda_d;
    logic [15:0] ctrl;
    logic [15:0] cur;
    logic [15:0] volt;
    logic overtemp;
    logic alarm;
    logic uv;
    logic src_on;
    logic chg_en;
    logic float_out;
    logic lim_out;
    logic [15:0] cur_out;
    logic [15:0] volt_out;
  } scp_regs_t;

  localparam scp_regs_t POR = '{
    st: scp_pkg::ST_IDLE,
    bitcnt: 4'h0,
    shreg: 8'h00,
    byte_buf: 8'h00,
    bytenum: 2'h0,
    rw: 1'b0,
    acked: 1'b0,
    cmd: 8'h00,
    sda_oe: 1'b0,
    scl_d: 1'b0,
    sda_d: 1'b0,
    ctrl: scp_pkg::CTRL_RST,
    cur: 16'h0000,
    volt: 16'h0000,
    overtemp: 1'b0,
    alarm: 1'b0,
    uv: 1'b0,
    src_on: 1'b0,
    chg_en: 1'b0,
    float_out: 1'b0,
    lim_out: 1'b0,
    cur_out: 16'h0000,
    volt_out: 16'h0000
  };

  scp_regs_t r_reg;
  scp_regs_t r_next;
  logic [scp_pkg::SYNC_W-1:0] s;
  logic start_det;
  logic stop_det;
  logic scl_rise;
  logic scl_fall;
  logic [15:0] status_word;
  logic [15:0] rd_word;
  logic [15:0] wr_word;
  logic [7:0] tx_shift;

  // Pins and analog comparator levels all come from outside this clock
  scp_sync #(
    .WIDTH(scp_pkg::SYNC_W)
  ) u_sync (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .i_ce(i_ce),
    .i_async({i_thermistor_underrange, i_overtemp_latched_flag, i_logic_supply_low, i_battery_sense_pin_above_resume,
              i_battery_sense_pin_below_low, i_battery_inserted_cmp, i_power_fail_cmp, i_adapter_detected, i_sda, i_scl}),
    .o_sync(s)
  );

  // ****************************************
  // Bus conditions
  // ****************************************
  assign start_det = s[scp_pkg::IX_SCL] & r_reg.scl_d & r_reg.sda_d & ~s[scp_pkg::IX_SDA];
  assign stop_det = s[scp_pkg::IX_SCL] & r_reg.scl_d & ~r_reg.sda_d & s[scp_pkg::IX_SDA];
  assign scl_rise = s[scp_pkg::IX_SCL] & ~r_reg.scl_d;
  assign scl_fall = ~s[scp_pkg::IX_SCL] & r_reg.scl_d;
  assign wr_word = {r_reg.shreg, r_reg.byte_buf};
  assign tx_shift = {r_reg.shreg[6:0], 1'b0};

  always_comb begin
    status_word = 16'h0000;
    status_word[scp_pkg::STAT_ADAPTER] = s[scp_pkg::IX_ADP];
    status_word[scp_pkg::STAT_BATTERY_SENSE_PIN] = s[scp_pkg::IX_BATTERY_SENSE_PIN];
    status_word[scp_pkg::STAT_PF] = s[scp_pkg::IX_PF];
    status_word[scp_pkg::STAT_ALARM] = r_reg.alarm;
    status_word[scp_pkg::STAT_OVERTEMP] = r_reg.overtemp;
    status_word[scp_pkg::STAT_UR] = s[scp_pkg::IX_UR];
    status_word[scp_pkg::STAT_UV] = r_reg.uv;
  end

  // Unknown read commands return zero rather than stalling the bus
  always_comb begin
    case (r_reg.cmd)
      scp_pkg::CMD_SPEC: rd_word = scp_pkg::SPEC_REV;
      scp_pkg::CMD_STAT: rd_word = status_word;
      default: rd_word = 16'h0000;
    endcase
  end

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    r_next = r_reg;
    if (i_ce) begin
      r_next.scl_d = s[scp_pkg::IX_SCL];
      r_next.sda_d = s[scp_pkg::IX_SDA];
      case (r_reg.st)
        scp_pkg::ST_IDLE: begin
          r_next.sda_oe = 1'b0;
        end
        scp_pkg::ST_RX: begin
          if (scl_rise) begin
            r_next.shreg = {r_reg.shreg[6:0], s[scp_pkg::IX_SDA]};
            r_next.bitcnt = r_reg.bitcnt + 4'h1;
          end else if (scl_fall && r_reg.bitcnt == scp_pkg::BYTE_BITS) begin
            r_next.st = scp_pkg::ST_ACK;
            r_next.sda_oe = 1'b1;
            case (r_reg.bytenum)
              2'h0: begin
                r_next.rw = r_reg.shreg[0];
                if (r_reg.shreg[7:1] != scp_pkg::DEV_ADDR) begin
                  r_next.st = scp_pkg::ST_IGNORE;
                  r_next.sda_oe = 1'b0;
                end
              end
              2'h1: r_next.cmd = r_reg.shreg;
              2'h2: r_next.byte_buf = r_reg.shreg;
              default: begin
                case (r_reg.cmd)
                  scp_pkg::CMD_CTRL: begin
                    r_next.ctrl = wr_word;
                    if (wr_word[scp_pkg::CTRL_POR]) begin
                      r_next.overtemp = 1'b0;
                      r_next.alarm = 1'b0;
                    end
                  end
                  scp_pkg::CMD_CUR: begin
                    r_next.cur = wr_word;
                    r_next.alarm = 1'b0;
                  end
                  scp_pkg::CMD_VOLT: begin
                    r_next.volt = wr_word;
                    r_next.alarm = 1'b0;
                  end
                  scp_pkg::CMD_ALARM: r_next.alarm = 1'b1;
                  default: r_next.alarm = r_reg.alarm;
                endcase
              end
            endcase
          end
        end
        scp_pkg::ST_ACK: begin
          if (scl_fall) begin
            r_next.bitcnt = 4'h0;
            r_next.sda_oe = 1'b0;
            if (r_reg.rw) begin
              // Low byte leaves first, high byte is parked for the second data byte
              r_next.shreg = rd_word[7:0];
              r_next.byte_buf = rd_word[15:8];
              r_next.sda_oe = ~rd_word[7];
              r_next.bytenum = 2'h0;
              r_next.st = scp_pkg::ST_TX;
            end else if (r_reg.bytenum == 2'h3) begin
              r_next.st = scp_pkg::ST_IGNORE;
            end else begin
              r_next.bytenum = r_reg.bytenum + 2'h1;
              r_next.st = scp_pkg::ST_RX;
            end
          end
        end
        scp_pkg::ST_TX: begin
          if (scl_fall) begin
            if (r_reg.bitcnt == scp_pkg::LAST_TX_BIT) begin
              r_next.sda_oe = 1'b0;
              r_next.acked = 1'b0;
              r_next.st = scp_pkg::ST_MACK;
            end else begin
              r_next.shreg = tx_shift;
              r_next.sda_oe = ~tx_shift[7];
              r_next.bitcnt = r_reg.bitcnt + 4'h1;
            end
          end
        end
        scp_pkg::ST_MACK: begin
          if (scl_rise) begin
            r_next.acked = ~s[scp_pkg::IX_SDA];
          end else if (scl_fall) begin
            if (r_reg.acked && r_reg.bytenum == 2'h0) begin
              r_next.shreg = r_reg.byte_buf;
              r_next.sda_oe = ~r_reg.byte_buf[7];
              r_next.bitcnt = 4'h0;
              r_next.bytenum = 2'h1;
              r_next.st = scp_pkg::ST_TX;
            end else begin
              r_next.st = scp_pkg::ST_IGNORE;
            end
          end
        end
        scp_pkg::ST_IGNORE: begin
          r_next.sda_oe = 1'b0;
        end
        default: begin
          r_next.st = scp_pkg::ST_IDLE;
          r_next.sda_oe = 1'b0;
        end
      endcase
      if (start_det) begin
        r_next.st = scp_pkg::ST_RX;
        r_next.bitcnt = 4'h0;
        r_next.bytenum = 2'h0;
        r_next.sda_oe = 1'b0;
      end else if (stop_det) begin
        r_next.st = scp_pkg::ST_IDLE;
        r_next.sda_oe = 1'b0;
      end

      // Battery and supply conditions override anything the bus just wrote
      if (!s[scp_pkg::IX_BATTERY_SENSE_PIN]) begin
        r_next.ctrl = scp_pkg::CTRL_RST;
        r_next.cur = 16'h0000;
        r_next.volt = 16'h0000;
        r_next.overtemp = 1'b0;
        r_next.alarm = 1'b0;
      end else if (s[scp_pkg::IX_HOT]) begin
        r_next.overtemp = 1'b1;
      end
      // Hysteresis between the two battery comparators
      if (s[scp_pkg::IX_LOW]) begin
        r_next.uv = 1'b1;
      end else if (s[scp_pkg::IX_RES]) begin
        r_next.uv = 1'b0;
      end

      r_next.src_on = ~s[scp_pkg::IX_PF];
      r_next.float_out = ~s[scp_pkg::IX_BATTERY_SENSE_PIN];
      r_next.lim_out = ~s[scp_pkg::IX_BATTERY_SENSE_PIN] | r_reg.uv;
      r_next.chg_en = s[scp_pkg::IX_ADP] & ~s[scp_pkg::IX_PF]
                      & (~s[scp_pkg::IX_BATTERY_SENSE_PIN]
                         | ~(r_reg.ctrl[scp_pkg::CTRL_HOLD] & r_reg.overtemp & ~s[scp_pkg::IX_UR]));
      r_next.cur_out = r_next.lim_out ? scp_pkg::LIMIT_MA : r_reg.cur;
      r_next.volt_out = s[scp_pkg::IX_BATTERY_SENSE_PIN] ? r_reg.volt : scp_pkg::FLOAT_MV;

      if (s[scp_pkg::IX_VDD]) begin
        r_next = POR;
      end
    end
  end

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      r_reg <= POR;
    end else begin
      r_reg <= r_next;
    end
  end

  // Open drain: only ever pulls low, and only as an answering slave
  assign o_sda_o = 1'b0;
  assign o_sda_oe = r_reg.sda_oe;
  assign o_source_switch_driver = r_reg.src_on;
  assign o_charge_enable = r_reg.chg_en;
  assign o_float_charge = r_reg.float_out;
  assign o_current_limited = r_reg.lim_out;
  assign o_current_setpoint = r_reg.cur_out;
  assign o_voltage_setpoint = r_reg.volt_out;
  assign o_control_word = r_reg.ctrl;

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_sys_rst);

  property p_slave_drive;
    o_sda_oe |-> (r_reg.st == scp_pkg::ST_ACK || r_reg.st == scp_pkg::ST_TX);
  endproperty
  a_slave_drive: assert property (p_slave_drive) else $error("sda driven outside ack or data phase");
  property p_start;
    i_ce && !s[scp_pkg::IX_VDD] && start_det |=> r_reg.st == scp_pkg::ST_RX && r_reg.bitcnt == 4'h0;
  endproperty
  a_start: assert property (p_start) else $error("start not taken");
  property p_spec;
    i_ce && !s[scp_pkg::IX_VDD] && !start_det && !stop_det && scl_fall && r_reg.st == scp_pkg::ST_ACK
      && r_reg.rw && r_reg.cmd == scp_pkg::CMD_SPEC |=> r_reg.shreg == scp_pkg::SPEC_REV[7:0] && r_reg.st == scp_pkg::ST_TX;
  endproperty
  a_spec: assert property (p_spec) else $error("revision word not loaded");
  property p_pf;
    i_ce && s[scp_pkg::IX_PF] |=> !o_source_switch_driver && !o_charge_enable;
  endproperty
  a_pf: assert property (p_pf) else $error("source switch on in power fail");
  property p_nobatt_regs;
    i_ce && !s[scp_pkg::IX_BATTERY_SENSE_PIN] |=> r_reg.ctrl == scp_pkg::CTRL_RST && r_reg.cur == 16'h0000 && r_reg.volt == 16'h0000;
  endproperty
  a_nobatt_regs: assert property (p_nobatt_regs) else $error("registers not reset without battery");
  property p_float;
    i_ce && !s[scp_pkg::IX_BATTERY_SENSE_PIN] && !s[scp_pkg::IX_VDD]
      |=> o_voltage_setpoint == scp_pkg::FLOAT_MV && o_current_setpoint == scp_pkg::LIMIT_MA && o_float_charge;
  endproperty
  a_float: assert property (p_float) else $error("float charge targets wrong");

  property p_uv;
    i_ce && !s[scp_pkg::IX_VDD] && s[scp_pkg::IX_LOW] ##1 i_ce && !s[scp_pkg::IX_VDD]
      |=> o_current_setpoint == scp_pkg::LIMIT_MA && o_current_limited;
  endproperty
  a_uv: assert property (p_uv) else $error("undervoltage current not limited");

  property p_vdd;
    i_ce && s[scp_pkg::IX_VDD] |=> !o_sda_oe && !o_charge_enable && r_reg.st == scp_pkg::ST_IDLE;
  endproperty
  a_vdd: assert property (p_vdd) else $error("active during logic supply low");

  property p_hold;
    i_ce && !s[scp_pkg::IX_BATTERY_SENSE_PIN] |=> r_reg.ctrl[scp_pkg::CTRL_HOLD];
  endproperty
  a_hold: assert property (p_hold) else $error("hold bit not restored");

  property p_latches;
    i_ce && !s[scp_pkg::IX_BATTERY_SENSE_PIN] |=> !r_reg.overtemp && !r_reg.alarm;
  endproperty
  a_latches: assert property (p_latches) else $error("latched flags not cleared");

  c_write: cover property (i_ce && r_reg.st == scp_pkg::ST_RX && r_reg.bytenum == 2'h3 && scl_fall
                           && r_reg.bitcnt == scp_pkg::BYTE_BITS);
  c_read: cover property (r_reg.st == scp_pkg::ST_TX && r_reg.bytenum == 2'h1);
  c_uv: cover property ($fell(r_reg.uv));

endmodule
`default_nettype wire

// ---- hw/scp_pkg.sv ----
// Constants, command codes, status layout and states of the charger command port
// How it works
// - Slave only, never starts bus traffic
// - Answers bus address 0x12 only
// - Detects START and STOP from clock and data
// - Commands use word read and word write
// - Command 0x11 reads fixed revision 0x01
// - Command 0x12 writes the control word
// - Command 0x13 reads the status word
// - Adapter present sets status bit 15
// - Power fail: source switch off, bit 13
// - Battery inserted sets status bit 14
// - No battery resets all command registers
// - No battery: float charge 18.32V, 128mA
// - Battery undervoltage limits current, keeps setpoint
// - Logic supply low: ignore bus, restart reset
// - Overheat hold bit returns to one
// - No battery or restore bit clears latches
// - New current or voltage clears alarm flag
package scp_pkg;

  // ****************************************
  // Bus address and command codes
  // ****************************************
  localparam logic [6:0] DEV_ADDR = 7'h12;
  localparam logic [7:0] CMD_SPEC = 8'h11;
  localparam logic [7:0] CMD_CTRL = 8'h12;
  localparam logic [7:0] CMD_STAT = 8'h13;
  localparam logic [7:0] CMD_CUR = 8'h14;
  localparam logic [7:0] CMD_VOLT = 8'h15;
  localparam logic [7:0] CMD_ALARM = 8'h16;

  // ****************************************
  // Register values and fields
  // ****************************************
  localparam logic [15:0] SPEC_REV = 16'h0001;
  localparam logic [15:0] CTRL_RST = 16'h0002;
  localparam int CTRL_HOLD = 1;
  localparam int CTRL_POR = 3;
  localparam int STAT_ADAPTER = 15;
  localparam int STAT_BATTERY_SENSE_PIN = 14;
  localparam int STAT_PF = 13;
  localparam int STAT_ALARM = 12;
  localparam int STAT_OVERTEMP = 11;
  localparam int STAT_UR = 10;
  localparam int STAT_UV = 9;
  localparam logic [15:0] FLOAT_MV = 16'h4790;
  localparam logic [15:0] LIMIT_MA = 16'h0080;
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [3:0] LAST_TX_BIT = 4'h7;

  // ****************************************
  // Synchronised input vector layout
  // ****************************************
  localparam int SYNC_W = 10;
  localparam int IX_SCL = 0;
  localparam int IX_SDA = 1;
  localparam int IX_ADP = 2;
  localparam int IX_PF = 3;
  localparam int IX_BATTERY_SENSE_PIN = 4;
  localparam int IX_LOW = 5;
  localparam int IX_RES = 6;
  localparam int IX_VDD = 7;
  localparam int IX_HOT = 8;
  localparam int IX_UR = 9;

  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_RX = 6'h02,
    ST_ACK = 6'h04,
    ST_TX = 6'h08,
    ST_MACK = 6'h10,
    ST_IGNORE = 6'h20
  } scp_state_t;

endpackage

// ---- hw/scp_sync.sv ----
// Two-stage synchroniser for pins and comparator levels
`timescale 1ns/1ps
`default_nettype none
module scp_sync #(
  parameter int WIDTH = 1
) (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_ce,
  input wire logic [WIDTH-1:0] i_async,
  output logic [WIDTH-1:0] o_sync
);
  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } scp_sync_t;

  scp_sync_t r_reg;
  scp_sync_t r_next;

  always_comb begin
    r_next = r_reg;
    if (i_ce) begin
      r_next.meta = i_async;
      r_next.stable = r_reg.meta;
    end
  end

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  assign o_sync = r_reg.stable;
endmodule
`default_nettype wire

// ---- testbench/scp_master_model.sv ----
// Bus master model that drives clock and data of the command port
`timescale 1ns/1ps
`default_nettype none
module scp_master_model (
  output logic o_scl,
  output logic o_sda_oe,
  input wire logic i_sda
);
  // ****************************************
  // Bit timing: 125 ns clock period
  // ****************************************
  localparam real Q = 31.25;
  initial begin
    o_scl = 1'b1;
    o_sda_oe = 1'b0;
  end
  // Also serves as repeated start; the clock stands high between frames
  task automatic start;
    o_sda_oe = 1'b0;
    #Q o_scl = 1'b1;
    #(2*Q) o_sda_oe = 1'b1;
    #(2*Q) o_scl = 1'b0;
    #Q;
  endtask
  task automatic stop;
    o_sda_oe = 1'b1;
    #Q o_scl = 1'b1;
    #(2*Q) o_sda_oe = 1'b0;
    #(2*Q);
  endtask
  task automatic bit_out(input logic b);
    o_sda_oe = !b;
    #Q o_scl = 1'b1;
    #(2*Q) o_scl = 1'b0;
    #Q;
  endtask
  task automatic bit_in(output logic b);
    o_sda_oe = 1'b0;
    #Q o_scl = 1'b1;
    #Q b = i_sda;
    #Q o_scl = 1'b0;
    #Q;
  endtask
  task automatic wr_byte(input logic [7:0] v, output logic ack);
    logic a;
    for (int i = 7; i >= 0; i--) begin
      bit_out(v[i]);
    end
    bit_in(a);
    ack = !a;
  endtask
  task automatic rd_byte(input logic last, output logic [7:0] v);
    for (int i = 7; i >= 0; i--) begin
      bit_in(v[i]);
    end
    bit_out(last);
  endtask
  // Keeps going after a missing acknowledge so the stop still closes the frame
  task automatic write_word(input logic [7:0] adr, input logic [7:0] cmd, input logic [15:0] w, output logic ok);
    logic a0, a1, a2, a3;
    start();
    wr_byte(adr, a0);
    wr_byte(cmd, a1);
    wr_byte(w[7:0], a2);
    wr_byte(w[15:8], a3);
    stop();
    ok = a0 & a1 & a2 & a3;
  endtask
  task automatic read_word(input logic [7:0] cmd, output logic [15:0] w, output logic ok);
    logic a0, a1, a2;
    start();
    wr_byte({scp_pkg::DEV_ADDR, 1'b0}, a0);
    wr_byte(cmd, a1);
    start();
    wr_byte({scp_pkg::DEV_ADDR, 1'b1}, a2);
    rd_byte(1'b0, w[7:0]);
    rd_byte(1'b1, w[15:8]);
    stop();
    ok = a0 & a1 & a2;
  endtask
endmodule
`default_nettype wire

// ---- testbench/testbench.sv ----
// Self-checking testbench of the charger command port
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic i_clk = 1'b0;
  logic i_sys_rst = 1'b1;
  // Adapter, power fail, battery, below low, above resume, logic low, hot, underrange
  logic [7:0] cond = 8'hA0;
  logic m_scl;
  logic m_oe;
  wire logic sda;
  logic o_sda_o, o_sda_oe, o_ssd, o_chg, o_float, o_lim;
  logic [15:0] o_cur, o_volt, o_ctrl;
  int n_mismatch = 0;
  int checks = 0;
  always #5 i_clk = ~i_clk;
  // Open drain data line with pull-up
  assign sda = !(m_oe | o_sda_oe);
  scp_master_model M (.o_scl(m_scl), .o_sda_oe(m_oe), .i_sda(sda));
  scp_command_port DUT (
    .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_ce(1'b1), .i_scl(m_scl), .i_sda(sda),
    .i_adapter_detected(cond[7]), .i_power_fail_cmp(cond[6]), .i_battery_inserted_cmp(cond[5]),
    .i_battery_sense_pin_below_low(cond[4]), .i_battery_sense_pin_above_resume(cond[3]), .i_logic_supply_low(cond[2]),
    .i_overtemp_latched_flag(cond[1]), .i_thermistor_underrange(cond[0]),
    .o_sda_o(o_sda_o), .o_sda_oe(o_sda_oe), .o_source_switch_driver(o_ssd), .o_charge_enable(o_chg),
    .o_float_charge(o_float), .o_current_limited(o_lim), .o_current_setpoint(o_cur),
    .o_voltage_setpoint(o_volt), .o_control_word(o_ctrl)
  );
  // ****************************************
  // Helpers
  // ****************************************
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic finish_test;
    $display("mismatches=%0d checks=%0d", n_mismatch, checks);
    if (n_mismatch == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // Comparators pass two synchroniser stages and up to two registers (uv or overtemp, then the output register); six cycles is ample
  task automatic set_cond(input logic [7:0] v);
    @(negedge i_clk);
    cond = v;
    repeat (6) @(negedge i_clk);
  endtask
  task automatic wr(input logic [7:0] adr, input logic [7:0] cmd, input logic [15:0] w, input logic ack);
    logic ok;
    // Start one nanosecond past a falling edge so no link edge lands on a clock edge
    @(negedge i_clk);
    #1;
    M.write_word(adr, cmd, w, ok);
    check({15'h0000, ok}, {15'h0000, ack});
    repeat (4) @(negedge i_clk);
  endtask
  task automatic rd(input logic [7:0] cmd, input logic [15:0] exp);
    logic [15:0] w;
    logic ok;
    @(negedge i_clk);
    #1;
    M.read_word(cmd, w, ok);
    check({15'h0000, ok}, 16'h0001);
    check(w, exp);
  endtask
  function automatic logic [15:0] pk(input logic a, input logic b, input logic c, input logic d);
    return {12'h000, a, b, c, d};
  endfunction
  // ****************************************
  // Tests
  // ****************************************
  localparam logic [7:0] WA = 8'h24;
  initial begin
    repeat (2) @(negedge i_clk);
    i_sys_rst = 1'b0;
    set_cond(8'hA0);
    check(o_ctrl, scp_pkg::CTRL_RST);
    check({15'h0000, o_sda_oe}, 16'h0000);
    rd(8'h11, 16'h0001);
    rd(8'h13, 16'hC000);
    set_cond(8'hE0);
    rd(8'h13, 16'hE000);
    check({15'h0000, o_ssd}, 16'h0000);
    set_cond(8'hA0);
    check(pk(o_ssd, o_chg, o_float, o_lim), 16'h000C);
    wr(WA, 8'h12, 16'h0000, 1'b1);
    check(o_ctrl, 16'h0000);
    set_cond(8'hA2);
    rd(8'h13, 16'hC800);
    check({15'h0000, o_chg}, 16'h0001);
    wr(WA, 8'h12, 16'h0002, 1'b1);
    check({15'h0000, o_chg}, 16'h0000);
    set_cond(8'hA0);
    wr(WA, 8'h12, 16'h0008, 1'b1);
    rd(8'h13, 16'hC000);
    wr(WA, 8'h16, 16'h0000, 1'b1);
    rd(8'h13, 16'hD000);
    wr(WA, 8'h14, 16'h0400, 1'b1);
    rd(8'h13, 16'hC000);
    wr(WA, 8'h16, 16'h0000, 1'b1);
    wr(WA, 8'h15, 16'h3000, 1'b1);
    rd(8'h13, 16'hC000);
    check(o_cur, 16'h0400);
    check(o_volt, 16'h3000);
    set_cond(8'hB0);
    check(o_cur, scp_pkg::LIMIT_MA);
    rd(8'h13, 16'hC200);
    set_cond(8'hA0);
    check({15'h0000, o_lim}, 16'h0001);
    set_cond(8'hA8);
    check(o_cur, 16'h0400);
    check({15'h0000, o_lim}, 16'h0000);
    wr(WA, 8'h12, 16'h0000, 1'b1);
    wr(WA, 8'h16, 16'h0000, 1'b1);
    set_cond(8'h80);
    check(o_ctrl, scp_pkg::CTRL_RST);
    check(o_volt, scp_pkg::FLOAT_MV);
    check(o_cur, scp_pkg::LIMIT_MA);
    check(pk(1'b0, 1'b0, o_float, o_lim), 16'h0003);
    rd(8'h13, 16'h8000);
    set_cond(8'hA0);
    check(o_cur, 16'h0000);
    wr({7'h13, 1'b0}, 8'h12, 16'h0000, 1'b0);
    check(o_ctrl, scp_pkg::CTRL_RST);
    set_cond(8'hA4);
    wr(WA, 8'h12, 16'h0000, 1'b0);
    check(o_ctrl, scp_pkg::CTRL_RST);
    check({15'h0000, o_chg}, 16'h0000);
    set_cond(8'hA0);
    rd(8'h11, 16'h0001);
    check({15'h0000, o_sda_oe}, 16'h0000);
    check({15'h0000, o_sda_o}, 16'h0000);
    finish_test();
  end
  initial begin
    #500us;
    n_mismatch++;
    finish_test();
  end
endmodule
`default_nettype wire
